// >>> rtl/accel_defines.svh
// constants for the accelerometer mode and output control block
`ifndef ACCEL_DEFINES_SVH
`define ACCEL_DEFINES_SVH
// output data start address
`define OUT_BASE_ADDR 8'h00
// full-scale codes
`define FS_2G 2'h0
`define FS_4G 2'h1
`define FS_8G 2'h2
// count shifts relative to 8 g (256 counts/g)
`define SHIFT_2G 4'h2
`define SHIFT_4G 4'h1
`define SHIFT_8G 4'h0
// self-test force in 8 g counts
`define SELF_TEST_FORCE 12'h040
// orientation trip points, tan-scaled: 30 deg ~ 0.577, 60 deg ~ 1.732 (x256)
`define TRIP_30_NUM 12'h093
`define TRIP_60_NUM 12'h1bb
// oversampling decimation shifts for the four settings
`define OSR_SHIFT_0 3'h1
`define OSR_SHIFT_1 3'h2
`define OSR_SHIFT_2 3'h3
`define OSR_SHIFT_3 3'h0
`define LNOISE_SHIFT 3'h1
// sample enable divider count at 200 MHz
`define SAMPLE_DIV 16'h00c7
`endif

// >>> rtl/accel_pkg.sv
// types for the accelerometer mode and output control block
package accel_pkg;
  typedef enum logic [1:0] {
    MODE_STANDBY,
    MODE_WAKE,
    MODE_SLEEP
  } sys_mode_e;
  typedef logic signed [11:0] sample_t;
endpackage : accel_pkg

// >>> rtl/accel_axis.sv
// one axis: scaling, self-test sum, oversampling filter
`timescale 1ns/10ps
`include "accel_defines.svh"
module accel_axis (
  input wire logic clk_sys_in, // system clock
  input wire logic reset_in, // async reset, active high
  input wire logic sample_en_in, // one-cycle sample strobe
  input wire logic clear_in, // standby-to-active clear
  input wire logic signed [11:0] raw_in, // raw sample, 8 g counts
  input wire logic [1:0] full_scale_in, // full-scale select
  input wire logic self_test_in, // self-test enable
  input wire logic [1:0] osr_in, // oversampling setting
  input wire logic low_noise_in, // low-noise enable
  output logic signed [11:0] value_out, // scaled sample
  output logic signed [11:0] hp_out // high-pass output
);
  logic signed [15:0] acc_r;
  logic signed [15:0] acc_nxt;
  logic signed [11:0] value_r;
  logic signed [11:0] prev_r;
  logic signed [11:0] hp_r;
  wire logic [3:0] scale_shift;
  wire logic [2:0] osr_shift;
  wire logic [2:0] tot_shift;
  wire logic signed [11:0] forced;
  wire logic signed [15:0] scaled;
  wire logic signed [15:0] sat;
  assign scale_shift = (full_scale_in == `FS_2G) ? `SHIFT_2G :
                       (full_scale_in == `FS_4G) ? `SHIFT_4G : `SHIFT_8G;
  assign forced = self_test_in ? 12'(raw_in + `SELF_TEST_FORCE) : raw_in;
  assign scaled = 16'(16'(signed'(forced)) <<< scale_shift);
  assign sat = (scaled > 16'sh07ff) ? 16'sh07ff : (scaled < -16'sh0800) ? -16'sh0800 : scaled;
  assign osr_shift = (osr_in == 2'h0) ? `OSR_SHIFT_0 : (osr_in == 2'h1) ? `OSR_SHIFT_1 :
                     (osr_in == 2'h2) ? `OSR_SHIFT_2 : `OSR_SHIFT_3;
  assign tot_shift = low_noise_in ? 3'(osr_shift + `LNOISE_SHIFT) : osr_shift;
  assign acc_nxt = 16'(acc_r + sat - (acc_r >>> tot_shift));
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      acc_r <= 16'sh0000;
      value_r <= 12'sh000;
      prev_r <= 12'sh000;
      hp_r <= 12'sh000;
    end else if (clear_in) begin
      acc_r <= 16'sh0000;
      prev_r <= 12'sh000;
      hp_r <= 12'sh000;
    end else if (sample_en_in) begin
      acc_r <= acc_nxt;
      value_r <= 12'(acc_nxt >>> tot_shift);
      prev_r <= value_r;
      hp_r <= 12'(value_r - prev_r);
    end
  end
  assign value_out = value_r;
  assign hp_out = hp_r;
endmodule : accel_axis

// >>> rtl/accel_mode_ctrl.sv
// accelerometer mode control, output data and event detection
`timescale 1ns/10ps
`include "accel_defines.svh"
module accel_mode_ctrl (
  input wire logic clk_sys_in, // system clock, 200 MHz
  input wire logic reset_in, // async reset, active high
  input wire logic power_good_in, // supply present (off when low)
  input wire logic active_req_in, // host control bit: 1 = active
  input wire logic sleep_req_in, // auto-sleep timeout reached
  input wire logic [1:0] full_scale_in, // range select
  input wire logic self_test_in, // self-test enable
  input wire logic [1:0] osr_in, // oversampling setting
  input wire logic low_noise_in, // low-noise enable
  input wire logic fast_read_in, // fast-read option
  input wire logic [11:0] transient_thr_in, // transient threshold
  input wire logic [35:0] raw_in, // raw x,y,z samples (async)
  input wire logic rd_en_in, // host read strobe
  input wire logic [7:0] rd_addr_in, // host read address
  output logic [7:0] rd_data_out, // read data
  output logic bus_ack_out, // bus responds
  output logic [1:0] system_mode_indicator_out, // current mode
  output logic analog_en_out, // analog subsystem enable
  output logic sample_clk_en_out, // sampling clock enable
  output logic [35:0] accel_out, // scaled x,y,z
  output logic transient_int_out, // transient interrupt
  output logic [2:0] transient_dir_out, // transient sign per axis
  output logic orient_int_out, // orientation change interrupt
  output logic portrait_out // orientation: 1 portrait
);
  // ***************************************
  // input sync and mode control
  // ***************************************
  logic [35:0] raw_s1_r;
  logic [35:0] raw_s2_r;
  logic [35:0] raw_s3_r;
  logic [35:0] raw_hold_r;
  // word used only after it stood unchanged for a cycle,
  // so a capture torn mid-change never reaches the axes
  wire logic raw_steady = (raw_s2_r == raw_s3_r);
  logic pg_s1_r;
  logic pg_s2_r;
  accel_pkg::sys_mode_e mode_r;
  accel_pkg::sys_mode_e mode_nxt;
  logic [15:0] div_r;
  logic clear_r;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      raw_s1_r <= 36'h0;
      raw_s2_r <= 36'h0;
      raw_s3_r <= 36'h0;
      raw_hold_r <= 36'h0;
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
    end else begin
      raw_s1_r <= raw_in;
      raw_s2_r <= raw_s1_r;
      raw_s3_r <= raw_s2_r;
      raw_hold_r <= raw_steady ? raw_s2_r : raw_hold_r;
      pg_s1_r <= power_good_in;
      pg_s2_r <= pg_s1_r;
    end
  end
  wire logic is_active = (mode_r != accel_pkg::MODE_STANDBY);
  always_comb begin
    case (mode_r)
      accel_pkg::MODE_STANDBY: mode_nxt = active_req_in ? accel_pkg::MODE_WAKE : accel_pkg::MODE_STANDBY;
      accel_pkg::MODE_WAKE: mode_nxt = !active_req_in ? accel_pkg::MODE_STANDBY :
                                       sleep_req_in ? accel_pkg::MODE_SLEEP : accel_pkg::MODE_WAKE;
      accel_pkg::MODE_SLEEP: mode_nxt = !active_req_in ? accel_pkg::MODE_STANDBY :
                                        sleep_req_in ? accel_pkg::MODE_SLEEP : accel_pkg::MODE_WAKE;
      default: mode_nxt = accel_pkg::MODE_STANDBY;
    endcase
  end
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      mode_r <= accel_pkg::MODE_STANDBY;
      clear_r <= 1'b0;
    end else if (!pg_s2_r) begin
      mode_r <= accel_pkg::MODE_STANDBY;
      clear_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      clear_r <= (mode_r == accel_pkg::MODE_STANDBY) && (mode_nxt != accel_pkg::MODE_STANDBY);
    end
  end
  // held at zero in standby: first strobe a full period after wake
  // divider runs only when active
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      div_r <= 16'h0000;
    end else if (!is_active || div_r == `SAMPLE_DIV) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= 16'(div_r + 16'h0001);
    end
  end
  wire logic sample_en = is_active && (div_r == `SAMPLE_DIV);
  // sleep and wake both enable all blocks
  // analog and clocks on when active
  assign analog_en_out = is_active && pg_s2_r;
  assign sample_clk_en_out = is_active && pg_s2_r;
  assign system_mode_indicator_out = 2'(mode_r);
  // bus answers in standby and active
  wire logic rd_ack = rd_en_in && pg_s2_r;
  assign bus_ack_out = rd_ack;

  // ***************************************
  // axis datapath
  // ***************************************
  logic [35:0] value_w;
  logic [35:0] hp_w;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_axis
      accel_axis axis_i (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .sample_en_in(sample_en),
        .clear_in(clear_r),
        .raw_in(raw_hold_r[g*12 +: 12]),
        .full_scale_in(full_scale_in),
        .self_test_in(self_test_in),
        .osr_in(osr_in),
        .low_noise_in(low_noise_in),
        .value_out(value_w[g*12 +: 12]),
        .hp_out(hp_w[g*12 +: 12])
      );
    end
  endgenerate
  assign accel_out = value_w;

  // ***************************************
  // transient and orientation detection
  // ***************************************
  function automatic logic [11:0] mag(input logic [11:0] v);
    mag = v[11] ? 12'(~v + 12'h001) : v;
  endfunction : mag
  wire logic [2:0] over;
  wire logic [2:0] sign;
  for (g = 0; g < 3; g = g + 1) begin : gen_thr
    assign over[g] = mag(hp_w[g*12 +: 12]) > transient_thr_in;
    assign sign[g] = hp_w[g*12 + 11];
  end
  wire logic [11:0] ax = mag(value_w[11:0]);
  wire logic [11:0] ay = mag(value_w[23:12]);
  wire logic [23:0] ay_30 = 24'(ay) * 24'(`TRIP_30_NUM);
  wire logic [23:0] ay_60 = 24'(ay) * 24'(`TRIP_60_NUM);
  // hysteresis between 30 and 60 degrees
  wire logic [23:0] ax_256 = {4'h0, ax, 8'h00};
  wire logic to_land = portrait_out && (ax_256 > ay_60);
  wire logic to_port = !portrait_out && (ax_256 < ay_30);
  // a set wins over a read strobe in the same cycle
  wire logic t_set = sample_en && (|over);
  wire logic o_set = sample_en && (to_land || to_port);
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      transient_int_out <= 1'b0;
      transient_dir_out <= 3'h0;
      orient_int_out <= 1'b0;
      portrait_out <= 1'b1;
    end else if (clear_r) begin
      transient_int_out <= 1'b0;
      transient_dir_out <= 3'h0;
      orient_int_out <= 1'b0;
    end else begin
      if (t_set) begin
        transient_int_out <= 1'b1;
        transient_dir_out <= sign;
      end else if (rd_ack) begin
        // host read acknowledges events
        transient_int_out <= 1'b0;
      end
      if (o_set) begin
        orient_int_out <= 1'b1;
        portrait_out <= to_port;
      end else if (rd_ack) begin
        orient_int_out <= 1'b0;
      end
    end
  end

  // ***************************************
  // output register read
  // ***************************************
  wire logic [7:0] idx = 8'(rd_addr_in - `OUT_BASE_ADDR);
  wire logic [1:0] axis_sel = fast_read_in ? 2'(idx) : 2'(idx >> 1);
  wire logic [11:0] axis_val = (axis_sel == 2'h0) ? value_w[11:0] :
                               (axis_sel == 2'h1) ? value_w[23:12] : value_w[35:24];
  wire logic [7:0] byte_val = (fast_read_in || !idx[0]) ? axis_val[11:4] : {axis_val[3:0], 4'h0};
  wire logic hit = fast_read_in ? (idx < 8'h03) : (idx < 8'h06);
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_ack) begin
      rd_data_out <= hit ? byte_val : 8'h00;
    end
  end
endmodule : accel_mode_ctrl

// >>> bench/accel_mode_ctrl_sva.sv
// port checker for the accelerometer mode control block
`timescale 1ns/10ps
module accel_mode_ctrl_sva (
  input wire logic clk_sys_in, // clock
  input wire logic reset_in, // reset
  input wire logic power_good_in, // supply
  input wire logic active_req_in, // run bit
  input wire logic sleep_req_in, // sleep
  input wire logic rd_en_in, // read
  input wire logic [7:0] rd_data_out, // byte
  input wire logic bus_ack_out, // ack
  input wire logic [1:0] system_mode_indicator_out, // mode
  input wire logic analog_en_out, // analog
  input wire logic sample_clk_en_out, // sampling
  input wire logic transient_int_out, // transient
  input wire logic orient_int_out, // orient
  input wire logic portrait_out // portrait
);
  // ***
  // properties
  // ***
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  wire logic stby = system_mode_indicator_out == 2'h0;
  // four samples cover the two-stage supply synchroniser
  sequence s_pwr;
    power_good_in [*4];
  endsequence
  sequence s_nopwr;
    !power_good_in [*4];
  endsequence
  sequence s_wakeup;
    stby ##1 !stby;
  endsequence
  AST_STBY_QUIET: assert property (stby |-> !analog_en_out && !sample_clk_en_out)
    else $error("standby enables on");
  AST_ACT_ON: assert property (s_pwr ##0 !stby |-> analog_en_out && sample_clk_en_out)
    else $error("active enables off");
  AST_WAKE: assert property (s_pwr ##0 (stby && active_req_in && !sleep_req_in) |=>
    system_mode_indicator_out == accel_pkg::MODE_WAKE) else $error("no wake");
  AST_SLEEP: assert property (s_pwr ##0 (!stby && active_req_in && sleep_req_in) |=>
    system_mode_indicator_out == 2'h2) else $error("no sleep");
  AST_TO_STBY: assert property (!stby && !active_req_in |=> stby)
    else $error("no standby");
  AST_OFF_ACK: assert property (s_nopwr |-> !bus_ack_out && stby)
    else $error("off but alive");
  AST_ACK_ON: assert property (s_pwr |-> bus_ack_out == rd_en_in)
    else $error("ack wrong");
  AST_ACK_CAUSE: assert property (bus_ack_out |-> rd_en_in)
    else $error("ack unasked");
  AST_HOLD: assert property (!(rd_en_in && bus_ack_out) |=> $stable(rd_data_out))
    else $error("data moved");
  AST_STBY_EVT: assert property (stby ##1 stby |->
    !$rose(transient_int_out) && !$rose(orient_int_out) && $stable(portrait_out)) else $error("standby event");
  AST_ACT_CLR: assert property (s_wakeup |=> !transient_int_out && !orient_int_out)
    else $error("flags kept on wake");
endmodule : accel_mode_ctrl_sva
bind accel_mode_ctrl accel_mode_ctrl_sva u_sva (.clk_sys_in, .reset_in, .power_good_in, .active_req_in,
  .sleep_req_in, .rd_en_in, .rd_data_out, .bus_ack_out, .system_mode_indicator_out, .analog_en_out,
  .sample_clk_en_out, .transient_int_out, .orient_int_out, .portrait_out);

// >>> bench/accel_host_model.sv
// host model: byte reads and the run control bit
`timescale 1ns/10ps
module accel_host_model (
  input wire logic clk_sys_in, // clock
  input wire logic [7:0] rd_data_in, // byte
  input wire logic bus_ack_in, // ack
  output logic rd_en_out, // read strobe
  output logic [7:0] rd_addr_out, // address
  output logic active_req_out // run bit
);
  int gap = 0;
  initial begin
    rd_en_out = 1'b0;
    rd_addr_out = 8'h00;
    active_req_out = 1'b0;
  end
  task automatic set_run(input logic b);
    @(posedge clk_sys_in) #1;
    active_req_out = b;
  endtask : set_run
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic k);
    repeat (gap) @(posedge clk_sys_in);
    @(posedge clk_sys_in) #1;
    rd_en_out = 1'b1;
    rd_addr_out = a;
    @(posedge clk_sys_in);
    k = bus_ack_in;
    #1;
    d = rd_data_in;
    rd_en_out = 1'b0;
    // released address is scrambled, not held
    rd_addr_out = ~a;
  endtask : rd
endmodule : accel_host_model

// >>> bench/accel_mode_ctrl_tb.sv
// self-checking bench for the accelerometer mode control block
`timescale 1ns/10ps
`include "accel_defines.svh"
module accel_mode_ctrl_tb;
  // ***
  // harness
  // ***
  logic clk_sys_in = 1'b0, reset_in = 1'b1, power_good_in = 1'b1, sleep_req_in = 1'b0;
  logic self_test_in = 1'b0, low_noise_in = 1'b0, fast_read_in = 1'b0, k;
  logic [1:0] full_scale_in = 2'h0, osr_in = 2'h3, system_mode_indicator_out;
  logic [11:0] transient_thr_in = 12'h010, x;
  logic [35:0] raw_in = '0, accel_out, r;
  logic rd_en_in, bus_ack_out, analog_en_out, sample_clk_en_out, active_req_in;
  logic transient_int_out, orient_int_out, portrait_out;
  logic [7:0] rd_addr_in, rd_data_out, d, d2;
  logic [2:0] transient_dir_out;
  int miscompares = 0, n_compared = 0, seed = 32'h991bc841;
  wire logic [2:0] flags = {portrait_out, orient_int_out, transient_int_out};
  accel_mode_ctrl u_accel_mode_ctrl (.clk_sys_in, .reset_in, .power_good_in, .active_req_in, .sleep_req_in,
    .full_scale_in, .self_test_in, .osr_in, .low_noise_in, .fast_read_in, .transient_thr_in, .raw_in, .rd_en_in,
    .rd_addr_in, .rd_data_out, .bus_ack_out, .system_mode_indicator_out, .analog_en_out, .sample_clk_en_out,
    .accel_out, .transient_int_out, .transient_dir_out, .orient_int_out, .portrait_out);
  accel_host_model u_accel_host_model (.clk_sys_in, .rd_data_in(rd_data_out), .bus_ack_in(bus_ack_out),
    .rd_en_out(rd_en_in), .rd_addr_out(rd_addr_in), .active_req_out(active_req_in));
  initial forever #2.5 clk_sys_in = ~clk_sys_in;
  task automatic tick();
    @(posedge clk_sys_in) #1;
  endtask : tick
  task automatic settle(input int n);
    repeat (n * int'(`SAMPLE_DIV + 16'h1) + 8) tick();
  endtask : settle
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic wait_lvl(input string n, input int b, input logic v);
    for (int i = 0; i < 4000 && flags[b] !== v; i++) tick();
    chk(n, v, flags[b]);
    if (flags[b] !== v) close_out();
  endtask : wait_lvl
  function automatic logic [11:0] rnd();
    return 12'($random(seed) % 1500);
  endfunction : rnd
  // scaled sum, clipped to the 12-bit range
  function automatic logic [11:0] expv(logic signed [11:0] a, logic [1:0] fs, logic st);
    int v;
    v = (int'(a) + (st ? int'(`SELF_TEST_FORCE) : 0)) * (fs == `FS_2G ? 4 : fs == `FS_4G ? 2 : 1);
    if (v > 2047) v = 2047;
    if (v < -2048) v = -2048;
    return 12'(v);
  endfunction : expv
  task automatic rd_all(input logic [35:0] q);
    logic [11:0] e;
    for (int a = 0; a < (fast_read_in ? 3 : 6); a++) begin
      e = expv(q[12 * (fast_read_in ? a : a / 2) +: 12], full_scale_in, self_test_in);
      u_accel_host_model.rd(8'(a), d, k);
      chk("ack", 1'b1, k);
      chk("rd", (!fast_read_in && a[0]) ? {e[3:0], 4'h0} : e[11:4], d);
    end
  endtask : rd_all
  // ***
  // scenarios
  // ***
  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    chk("mode", 2'h0, system_mode_indicator_out);
    repeat (3) tick();
    for (int i = 0; i < 6; i++) begin
      r = {rnd(), rnd(), rnd()};
      full_scale_in = 2'(i % 3);
      self_test_in = 1'($random(seed));
      fast_read_in = 1'($random(seed));
      u_accel_host_model.gap = $unsigned($random(seed)) % 4;
      raw_in = r;
      u_accel_host_model.set_run(1'b1);
      tick();
      chk("wake", accel_pkg::MODE_WAKE, system_mode_indicator_out);
      chk("analog", 1'b1, analog_en_out);
      settle(2);
      rd_all(r);
      u_accel_host_model.set_run(1'b0);
      tick();
      chk("stby", 2'h0, system_mode_indicator_out);
      raw_in = ~r;
      settle(2);
      rd_all(r);
    end
    u_accel_host_model.set_run(1'b1);
    sleep_req_in = 1'b1;
    repeat (2) tick();
    chk("sleep", 2'h2, system_mode_indicator_out);
    chk("sclk", 1'b1, sample_clk_en_out);
    sleep_req_in = 1'b0;
    u_accel_host_model.rd(8'h40, d, k);
    chk("unmapped", 8'h00, d);
    power_good_in = 1'b0;
    repeat (4) tick();
    chk("offmode", 2'h0, system_mode_indicator_out);
    u_accel_host_model.rd(8'h01, d2, k);
    chk("offack", 1'b0, k);
    chk("offdata", d, d2);
    power_good_in = 1'b1;
    raw_in = r;
    fast_read_in = 1'b0;
    self_test_in = 1'b0;
    full_scale_in = `FS_8G;
    for (int o = 0; o < 3; o++) begin
      osr_in = 2'(o);
      low_noise_in = o[0];
      u_accel_host_model.set_run(1'b0);
      u_accel_host_model.set_run(1'b1);
      settle(80);
      x = accel_out[11:0] - r[11:0];
      chk("osr", 1'b1, x + 12'h8 < 12'h11);
    end
    osr_in = 2'h3;
    low_noise_in = 1'b0;
    raw_in = 36'h000300000;
    settle(3);
    chk("portrait", 1'b1, portrait_out);
    u_accel_host_model.rd(8'h00, d, k);
    chk("rdclr", 2'b00, {transient_int_out, orient_int_out});
    raw_in = 36'h000000300;
    wait_lvl("landscape", 2, 1'b0);
    chk("oint", 1'b1, orient_int_out);
    wait_lvl("tint", 0, 1'b1);
    chk("tdir", 3'b010, transient_dir_out);
    raw_in = 36'h000200200;
    settle(3);
    chk("hyst", 1'b0, portrait_out);
    raw_in = 36'h000300000;
    wait_lvl("back", 2, 1'b1);
    u_accel_host_model.set_run(1'b0);
    tick();
    chk("keep", 1'b1, orient_int_out);
    u_accel_host_model.set_run(1'b1);
    repeat (2) tick();
    chk("actclr", 2'b00, {transient_int_out, orient_int_out});
    close_out();
  end
endmodule : accel_mode_ctrl_tb
